// *** hw/hsce_consts.svh ***
// Register offsets, field positions and reset values of the channel enable block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef HSCE_CONSTS_SVH
`define HSCE_CONSTS_SVH
`define HSCE_ADDR_INPUT_STATUS 8'h32
`define HSCE_ADDR_CHANNEL_ENABLE 8'h3B
`define HSCE_INPUT_STATUS_RESET 8'h00
`define HSCE_SW_VOTE_RESET 1'h0
`define HSCE_BIT_CH1_SW 0
`define HSCE_BIT_CH1_HW 1
`define HSCE_BIT_CH2_SW 2
`define HSCE_BIT_CH2_HW 3
`define HSCE_BIT_GROUP 4
`define HSCE_BIT_PROT_LO 6
`define HSCE_BIT_PROT_HI 7
`define HSCE_PROT_NOT_POSSIBLE 2'h3
`endif

// *** hw/hsce_pkg.sv ***
// Types shared by the channel enable block.
// Assumes the constants header sits alongside.
`include "hsce_consts.svh"
package hsce_pkg;
  typedef enum logic [1:0] {
    HSCE_PROT_ALERT,
    HSCE_PROT_ALERT_PG,
    HSCE_PROT_ALERT_PG_OFF
  } hsce_prot_type;
  typedef enum {
    HSCE_LOCKED,
    HSCE_RUN
  } hsce_supply_type;
endpackage : hsce_pkg

// *** hw/hsce_channel_ctrl.sv ***
// Channel on/off decision logic of a dual hot-swap controller.
// Assumes an I2C slave elsewhere turns frames into byte writes and reads at
// register addresses; analog comparators and straps arrive as asynchronous levels.
// How it works
// - Channel enabled when at least two of three votes are one.
// - Switch on only while supply above lockout and majority enable true.
// - On supply rising above lockout, hardware votes load from strap input.
// - On-pin comparator above 0.6V sets status bit; bit0 ch1, bit1 ch2.
// - Software votes reset to zero; host may write software and hardware votes.
// - Grouping low: channels independent, one fault leaves other running.
// - Grouping high or open: fault on either channel shuts both down.
// - Paired grouping lets both channels share the one monitoring converter.
// - Status bit 4 reads 0 grouped, 1 independent.
// - Status bits 7:6 report critical-fault action; code 11 never occurs.
// - Enable register 0x3B: ch1 sw/hw bits 0/1, ch2 sw/hw bits 2/3.
`timescale 1ns/1ps
`default_nettype none
`include "hsce_consts.svh"
module hsce_channel_ctrl
  import hsce_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic supply_above_lockout,
  input wire logic hw_enable_strap,
  input wire logic pin_level_ch1,
  input wire logic pin_level_ch2,
  input wire logic group_low,
  input wire logic [1:0] prot_code,
  input wire logic [1:0] fault_shutdown,
  output logic [1:0] switch_on,
  output logic [1:0] channel_enable,
  output logic adc_shared
);

  // Elaboration stops here; fault pairing is written for exactly two channels
  if (CHANNELS != 2) begin : g_channels_check
    $error("hsce_channel_ctrl serves exactly two channels");
  end

  // Two-flop synchronisers; first stage read only by second stage
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [1:0] prot1_r;
  logic [1:0] prot2_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prot1_r <= 2'h0;
      prot2_r <= 2'h0;
    end else begin
      sync1_r <= {supply_above_lockout, hw_enable_strap, pin_level_ch2, pin_level_ch1,
                  group_low};
      sync2_r <= sync1_r;
      prot1_r <= prot_code;
      prot2_r <= prot1_r;
    end
  end

  logic supply_ok;
  logic strap_s;
  logic [1:0] pin_s;
  logic indep_s;
  assign supply_ok = sync2_r[4];
  assign strap_s = sync2_r[3];
  assign pin_s = sync2_r[2:1];
  assign indep_s = sync2_r[0];

  // Supply lockout tracking, used to catch the strap on the rising edge
  hsce_supply_type supply_r;
  logic supply_rise;
  assign supply_rise = (supply_r == HSCE_LOCKED) && supply_ok;
  always_ff @(posedge clk) begin
    if (reset) begin
      supply_r <= HSCE_LOCKED;
    end else begin
      case (supply_r)
        HSCE_LOCKED: begin
          if (supply_ok) begin
            supply_r <= HSCE_RUN;
          end
        end
        default: begin
          if (!supply_ok) begin
            supply_r <= HSCE_LOCKED;
          end
        end
      endcase
    end
  end

  // Enable votes; strap reload on supply rise wins over a host write that cycle
  logic [1:0] sw_enable_vote_r;
  logic [1:0] hw_enable_vote_r;
  logic wr_en;
  assign wr_en = reg_write && (reg_addr == `HSCE_ADDR_CHANNEL_ENABLE);
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_enable_vote_r <= {2{`HSCE_SW_VOTE_RESET}};
    end else if (wr_en) begin
      sw_enable_vote_r <= {reg_wdata[`HSCE_BIT_CH2_SW], reg_wdata[`HSCE_BIT_CH1_SW]};
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      hw_enable_vote_r <= 2'h0;
    end else if (supply_rise) begin
      hw_enable_vote_r <= {2{strap_s}};
    end else if (wr_en) begin
      hw_enable_vote_r <= {reg_wdata[`HSCE_BIT_CH2_HW], reg_wdata[`HSCE_BIT_CH1_HW]};
    end
  end

  // Majority per channel, combined with fault grouping
  logic [1:0] majority;
  logic [1:0] shut;
  logic any_fault;
  assign any_fault = |fault_shutdown;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign majority[ch] = (sw_enable_vote_r[ch] & hw_enable_vote_r[ch])
                          | (sw_enable_vote_r[ch] & pin_s[ch])
                          | (hw_enable_vote_r[ch] & pin_s[ch]);
      assign shut[ch] = indep_s ? fault_shutdown[ch] : any_fault;
    end
  endgenerate

  // Outputs re-evaluated every cycle from registered state and the unsynchronised fault_shutdown input
  always_ff @(posedge clk) begin
    if (reset) begin
      channel_enable <= 2'h0;
      switch_on <= 2'h0;
      adc_shared <= 1'b0;
    end else begin
      channel_enable <= majority;
      switch_on <= majority & {2{supply_ok}} & ~shut;
      adc_shared <= ~indep_s;
    end
  end

  // Read data: status and enable registers, other addresses read zero
  logic [7:0] status_val;
  logic [1:0] prot_s;
  // Code 11 cannot arise from a three-state pin; fold it to shutdown action
  assign prot_s = (prot2_r == `HSCE_PROT_NOT_POSSIBLE)
                ? 2'(HSCE_PROT_ALERT_PG_OFF) : prot2_r;
  always_comb begin
    status_val = `HSCE_INPUT_STATUS_RESET;
    status_val[1:0] = pin_s;
    status_val[`HSCE_BIT_GROUP] = indep_s;
    status_val[`HSCE_BIT_PROT_HI:`HSCE_BIT_PROT_LO] = prot_s;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `HSCE_ADDR_INPUT_STATUS) begin
      reg_rdata <= status_val;
    end else if (reg_addr == `HSCE_ADDR_CHANNEL_ENABLE) begin
      reg_rdata <= {4'h0, hw_enable_vote_r[1], sw_enable_vote_r[1],
                    hw_enable_vote_r[0], sw_enable_vote_r[0]};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks on registered state; a broken path shows one cycle after its cause, except chk_switch_majority, which checks the same cycle
  chk_majority_on: assert property (@(posedge clk) disable iff (reset)
    ($countones({sw_enable_vote_r[0], hw_enable_vote_r[0], pin_s[0]}) >= 2)
    |=> channel_enable[0])
    else $error("channel 1 enable missing with two votes");
  chk_ch2_majority_on: assert property (@(posedge clk) disable iff (reset)
    ($countones({sw_enable_vote_r[1], hw_enable_vote_r[1], pin_s[1]}) >= 2)
    |=> channel_enable[1])
    else $error("channel 2 enable missing with two votes");
  chk_majority_off: assert property (@(posedge clk) disable iff (reset)
    ($countones({sw_enable_vote_r[1], hw_enable_vote_r[1], pin_s[1]}) < 2)
    |=> !channel_enable[1])
    else $error("channel 2 enable held with fewer than two votes");
  chk_ch1_majority_off: assert property (@(posedge clk) disable iff (reset)
    ($countones({sw_enable_vote_r[0], hw_enable_vote_r[0], pin_s[0]}) < 2)
    |=> !channel_enable[0])
    else $error("channel 1 enable held with fewer than two votes");
  chk_lockout_gate: assert property (@(posedge clk) disable iff (reset)
    !supply_ok
    |=> switch_on == 2'h0)
    else $error("switch on while supply locked out");
  chk_switch_majority: assert property (@(posedge clk) disable iff (reset)
    (switch_on & ~channel_enable) == 2'h0)
    else $error("switch on without majority enable");
  chk_switch_ready: assert property (@(posedge clk) disable iff (reset)
    (majority == 2'h3 && supply_ok && !any_fault)
    |=> switch_on == 2'h3)
    else $error("switch off although all turn-on conditions hold");
  chk_strap_load: assert property (@(posedge clk) disable iff (reset)
    supply_rise
    |=> hw_enable_vote_r == {2{$past(strap_s)}})
    else $error("hardware votes not loaded from strap");
  chk_hw_hold: assert property (@(posedge clk) disable iff (reset)
    (!wr_en && !supply_rise)
    |=> $stable(hw_enable_vote_r))
    else $error("hardware votes changed with no write or supply rise");
  chk_rise_once: assert property (@(posedge clk) disable iff (reset)
    supply_rise
    |=> !supply_rise)
    else $error("supply rise seen twice in a row");
  chk_status_pins: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS)
    |=> reg_rdata[1:0] == $past(pin_s))
    else $error("on-pin status bits wrong");
  chk_sw_write: assert property (@(posedge clk) disable iff (reset)
    wr_en
    |=> sw_enable_vote_r == {$past(reg_wdata[2]), $past(reg_wdata[0])})
    else $error("software vote write lost");
  chk_hw_write: assert property (@(posedge clk) disable iff (reset)
    (wr_en && !supply_rise)
    |=> hw_enable_vote_r == {$past(reg_wdata[3]), $past(reg_wdata[1])})
    else $error("hardware vote write lost");
  chk_sw_hold: assert property (@(posedge clk) disable iff (reset)
    !wr_en
    |=> $stable(sw_enable_vote_r))
    else $error("software votes changed with no write");
  chk_sw_reset: assert property (@(posedge clk)
    reset
    |=> sw_enable_vote_r == 2'h0)
    else $error("software votes not cleared by reset");
  chk_indep_fault: assert property (@(posedge clk) disable iff (reset)
    (indep_s && !fault_shutdown[1] && majority[1] && supply_ok)
    |=> switch_on[1])
    else $error("independent channel 2 shut by other fault");
  chk_ch1_indep_fault: assert property (@(posedge clk) disable iff (reset)
    (indep_s && !fault_shutdown[0] && majority[0] && supply_ok)
    |=> switch_on[0])
    else $error("independent channel 1 shut by other fault");
  chk_ch1_own_fault: assert property (@(posedge clk) disable iff (reset)
    fault_shutdown[0]
    |=> !switch_on[0])
    else $error("channel 1 left on after its own fault");
  chk_ch2_own_fault: assert property (@(posedge clk) disable iff (reset)
    fault_shutdown[1]
    |=> !switch_on[1])
    else $error("channel 2 left on after its own fault");
  chk_paired_fault: assert property (@(posedge clk) disable iff (reset)
    (!indep_s && any_fault)
    |=> switch_on == 2'h0)
    else $error("paired channel left on after fault");
  chk_paired_cross: assert property (@(posedge clk) disable iff (reset)
    (!indep_s && fault_shutdown[1])
    |=> !switch_on[0])
    else $error("channel 1 left on after paired channel 2 fault");
  chk_adc_share: assert property (@(posedge clk) disable iff (reset)
    !indep_s
    |=> adc_shared)
    else $error("converter not shared when paired");
  chk_adc_indep: assert property (@(posedge clk) disable iff (reset)
    indep_s
    |=> !adc_shared)
    else $error("converter shared in independent mode");
  chk_group_bit: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS)
    |=> reg_rdata[4] == !adc_shared)
    else $error("grouping status bit wrong");
  chk_status_group: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS)
    |=> reg_rdata[4] == $past(indep_s))
    else $error("grouping status bit not from mode input");
  chk_status_unused: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS)
    |=> {reg_rdata[5], reg_rdata[3:2]} == 3'h0)
    else $error("unused status bits not zero");
  chk_prot_code: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS)
    |=> reg_rdata[7:6] != 2'h3)
    else $error("impossible protection code reported");
  chk_prot_report: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS && prot2_r != `HSCE_PROT_NOT_POSSIBLE)
    |=> reg_rdata[7:6] == $past(prot2_r))
    else $error("protection code not reported as sampled");
  chk_prot_fold: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_INPUT_STATUS && prot2_r == `HSCE_PROT_NOT_POSSIBLE)
    |=> reg_rdata[7:6] == 2'(HSCE_PROT_ALERT_PG_OFF))
    else $error("impossible protection code not folded to shutdown action");
  chk_enable_upper: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_CHANNEL_ENABLE)
    |=> reg_rdata[7:4] == 4'h0)
    else $error("enable register upper bits not zero");
  chk_enable_read: assert property (@(posedge clk) disable iff (reset)
    (reg_addr == `HSCE_ADDR_CHANNEL_ENABLE)
    |=> reg_rdata[3:0] == {$past(hw_enable_vote_r[1]), $past(sw_enable_vote_r[1]),
                           $past(hw_enable_vote_r[0]), $past(sw_enable_vote_r[0])})
    else $error("enable register read does not match votes");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
    (reg_addr != `HSCE_ADDR_INPUT_STATUS && reg_addr != `HSCE_ADDR_CHANNEL_ENABLE)
    |=> reg_rdata == 8'h00)
    else $error("unmapped address read not zero");
  chk_other_write: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr != `HSCE_ADDR_CHANNEL_ENABLE)
    |=> $stable(sw_enable_vote_r))
    else $error("write to another address changed software votes");

endmodule : hsce_channel_ctrl
`default_nettype wire

// *** verification/hsce_host_model.sv ***
// Host-side model: register writes and address selection for the enable block.
// Assumes a free-running clock; every request changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hsce_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  // Data inverted after the strobe so a stale byte never looks valid
  task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~data;
  endtask : wr_byte
  task automatic select(input logic [7:0] addr);
    @(posedge clk);
    reg_addr <= addr;
  endtask : select
endmodule : hsce_host_model
`default_nettype wire

// *** verification/hsce_channel_ctrl_test.sv ***
// Self-checking bench for the channel enable block.
// Assumes the design package is compiled first; expectations queue to a monitor.
`timescale 1ns/1ps
`default_nettype none
module hsce_channel_ctrl_test;
  import hsce_pkg::*;
  logic clk = 1'b0, reset = 1'b1, supply_above_lockout = 1'b0, hw_enable_strap = 1'b1;
  logic pin_level_ch1 = 1'b0, pin_level_ch2 = 1'b0, group_low = 1'b0, chk_req = 1'b0;
  logic [1:0] prot_code = 2'h0, fault_shutdown = 2'h0, switch_on, channel_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_write, adc_shared;
  logic [8:0] exp_q[$];
  logic [8:0] got;
  logic [2:0] i3, j3;
  logic [1:0] prot_exp;
  int failures = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  hsce_host_model i_hsce_host_model (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata));
  hsce_channel_ctrl #(.CHANNELS(2)) i_hsce_channel_ctrl (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_above_lockout(supply_above_lockout), .hw_enable_strap(hw_enable_strap),
    .pin_level_ch1(pin_level_ch1), .pin_level_ch2(pin_level_ch2), .group_low(group_low),
    .prot_code(prot_code), .fault_shutdown(fault_shutdown), .switch_on(switch_on),
    .channel_enable(channel_enable), .adc_shared(adc_shared));
  function automatic logic maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj
  task automatic summarize();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Extra edge at the end keeps back-to-back notes from double-driving the flag
  task automatic note(input logic kind, input logic [7:0] val);
    exp_q.push_back({kind, val});
    chk_req <= 1'b1;
    @(posedge clk);
    chk_req <= 1'b0;
    @(posedge clk);
  endtask : note
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] val);
    i_hsce_host_model.select(addr);
    repeat (3) @(posedge clk);
    note(1'b0, val);
  endtask : check_reg
  // Five edges cover the two-stage input sync plus the output register
  task automatic check_out(input logic [1:0] sw, input logic [1:0] en, input logic adc);
    repeat (5) @(posedge clk);
    note(1'b1, {3'h0, adc, sw, en});
  endtask : check_out
  task automatic compare_byte(input logic [7:0] val);
    cmp_count++;
    if (reg_rdata !== val) begin
      failures++;
      $display("unexpected %0t read %h want %h", $time, reg_rdata, val);
    end
  endtask : compare_byte
  task automatic compare_out(input logic [7:0] val);
    cmp_count++;
    if ({3'h0, adc_shared, switch_on, channel_enable} !== val) begin
      failures++;
      $display("unexpected %0t outputs %b%b%b want %b", $time, adc_shared, switch_on,
        channel_enable, val[4:0]);
    end
  endtask : compare_out
  always @(posedge clk) begin
    if (chk_req) begin
      got = exp_q.pop_front();
      if (got[8]) compare_out(got[7:0]);
      else compare_byte(got[7:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(32'h1B2C));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    check_reg(8'h3B, 8'h00);
    check_reg(8'h32, 8'h00);
    supply_above_lockout <= 1'b1;
    check_reg(8'h3B, 8'h0A);
    check_out(2'b00, 2'b00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      i3 = i[2:0];
      j3 = 3'($urandom % 8);
      i_hsce_host_model.wr_byte(8'h3B, {4'($urandom), j3[1:0], i3[1:0]});
      pin_level_ch1 <= i3[2];
      pin_level_ch2 <= j3[2];
      check_out({maj(j3), maj(i3)}, {maj(j3), maj(i3)}, 1'b1);
      check_reg(8'h3B, {4'h0, j3[1:0], i3[1:0]});
      check_reg(8'h32, {6'h00, j3[2], i3[2]});
    end
    // Code 11 cannot come from the pin; it reads back as the shutdown action
    for (int p = 0; p < 4; p++) begin
      prot_code <= 2'(p);
      group_low <= p[0];
      prot_exp = (p == 3) ? 2'h2 : 2'(p);
      check_reg(8'h32, {prot_exp, 1'b0, p[0], 2'h0, pin_level_ch2, pin_level_ch1});
    end
    i_hsce_host_model.wr_byte(8'h3B, 8'h0F);
    group_low <= 1'b1;
    fault_shutdown <= 2'b01;
    check_out(2'b10, 2'b11, 1'b0);
    group_low <= 1'b0;
    check_out(2'b00, 2'b11, 1'b1);
    fault_shutdown <= 2'b00;
    supply_above_lockout <= 1'b0;
    check_out(2'b00, 2'b11, 1'b1);
    i_hsce_host_model.wr_byte(8'h32, 8'hFF);
    i_hsce_host_model.wr_byte(8'h40, 8'h00);
    check_reg(8'h40, 8'h00);
    check_reg(8'h3B, 8'h0F);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge clk);
    if (exp_q.size() > 0) failures++;
    summarize();
  end
endmodule : hsce_channel_ctrl_test
`default_nettype wire
